// [testbench/perf_event_counter_gating_irq_tb.sv]
// self-checking bench for the event counter gating block
`timescale 1ns/100ps
module perf_event_counter_gating_irq_tb;
    // ************************************************
    // stimulus, checks and verdict
    // ************************************************
    logic        clk, rst, wr, rd, priv, idx, bit5, sec, usr, sun;
    logic        dbg, ndbg, sdbg, sndbg, rvalid, fault, evok, cyok, irq;
    logic [3:0]  crm, crn;
    logic [2:0]  opc2, ovf;
    logic [31:0] wdata, rdata;
    logic [4:0]  sel0, sel1;
    logic [29:0] ebus;
    logic [1:0]  cen, eovf;
    logic [9:0]  rows [9] = '{10'h001, 10'h004, 10'h087, 10'h0D7, 10'h094, 10'h099,
                              10'h0BF, 10'h0B4, 10'h317};
    int          n_mismatch = 0;
    int          samples_checked = 0;
    perf_event_counter_gating_irq u_dut (.SYS_CLK_I(clk), .RST_I(rst), .CP_WR_I(wr),
        .CP_RD_I(rd), .CP_CRN_I(crn), .CP_CRM_I(crm), .CP_OPC2_I(opc2), .CP_WDATA_I(wdata),
        .CP_PRIV_I(priv), .CP_RDATA_O(rdata), .CP_RVALID_O(rvalid), .CP_FAULT_O(fault),
        .COUNTER_INDEX_I(idx), .EVENT_TYPE_SELECT0_I(sel0), .EVENT_TYPE_SELECT1_I(sel1),
        .EVENT_BUS_I(ebus), .COUNT_ENABLE_I(cen), .MONITOR_CONTROL_BIT5_I(bit5),
        .OVF_PENDING_I(ovf), .SECURE_STATE_I(sec), .USER_MODE_I(usr),
        .SECURE_USER_NONINVASIVE_BIT_I(sun), .INVASIVE_DEBUG_ALLOW_I(dbg),
        .NONINVASIVE_DEBUG_ALLOW_I(ndbg), .SECURE_INVASIVE_DEBUG_ALLOW_I(sdbg),
        .SECURE_NONINVASIVE_DEBUG_ALLOW_I(sndbg), .EVENT_COUNT_ALLOW_O(evok),
        .CYCLE_TALLY_ALLOW_O(cyok), .EVENT_OVF_O(eovf), .MONITOR_IRQ_OUT_O(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one transfer; outputs settle after the edge that takes it
    task automatic acc(input logic w, input logic [3:0] m, input logic [2:0] o,
                       input logic [31:0] d, input logic p);
        @(posedge clk);
        {wr, rd, crm, opc2, wdata, priv} <= {w, !w, m, o, d, p};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1;
    endtask
    task automatic t_user;
        acc(0, 4'hE, 3'h0, 32'h0, 1'b1); chk(rdata, 32'h0);
        acc(1, 4'hE, 3'h0, 32'hFFFFFFFF, 1'b0); chk(fault, 1);
        acc(0, 4'hE, 3'h0, 32'h0, 1'b0); chk(rdata, 32'h0);
        acc(1, 4'hE, 3'h0, 32'hFFFFFFFF, 1'b1);
        acc(0, 4'hE, 3'h0, 32'h0, 1'b0); chk(rdata, 32'h1);
    endtask
    task automatic t_irq;
        acc(1, 4'hE, 3'h1, 32'hFFFFFFFF, 1'b1);
        acc(0, 4'hE, 3'h1, 32'h0, 1'b1); chk(rdata, 32'h80000003);
        acc(1, 4'hE, 3'h2, 32'h1, 1'b1);
        acc(0, 4'hE, 3'h2, 32'h0, 1'b1); chk(rdata, 32'h80000002);
        acc(1, 4'hE, 3'h1, 32'h0, 1'b1);
        acc(0, 4'hE, 3'h1, 32'h0, 1'b1); chk(rdata, 32'h80000002);
        acc(1, 4'hE, 3'h2, 32'hFFFFFFFF, 1'b0); chk(fault, 1);
        acc(0, 4'hE, 3'h2, 32'h0, 1'b1); chk(rdata, 32'h80000002);
    endtask
    // a transfer outside the c9 space must read zero, raise no fault and not alter the enables
    task automatic t_unmapped;
        @(posedge clk) crn <= 4'h8;
        acc(0, 4'hE, 3'h1, 32'h0, 1'b1); chk(rdata, 32'h0);
        acc(1, 4'hE, 3'h2, 32'hFFFFFFFF, 1'b1); chk(fault, 0);
        @(posedge clk) crn <= 4'h9;
        acc(0, 4'hE, 3'h1, 32'h0, 1'b1); chk(rdata, 32'h80000002);
    endtask
    task automatic t_irqout;
        @(posedge clk) ovf <= 3'h1;
        wait_clk(3); chk(irq, 0);
        @(posedge clk) ovf <= 3'h2;
        wait_clk(3); chk(irq, 1);
        acc(1, 4'hE, 3'h2, 32'h2, 1'b1);
        wait_clk(3); chk(irq, 0);
        @(posedge clk) ovf <= 3'h4;
        wait_clk(3); chk(irq, 1);
    endtask
    // rows: inv, sec inv, noninv, sec noninv, user bit, secure, user, bit5, event ok, cycle ok
    task automatic t_gate;
        foreach (rows[i]) begin
            @(posedge clk);
            {dbg, sdbg, ndbg, sndbg, sun, sec, usr, bit5} <= rows[i][9:2];
            wait_clk(6);
            chk(evok, rows[i][1]);
            chk(cyok, rows[i][0]);
        end
    endtask
    task automatic t_count;
        int k;
        @(posedge clk);
        {sec, dbg, ndbg, sel0, sel1, cen} <= {3'b010, 5'h3, 5'h5, 2'b11};
        idx <= 1'b0;
        acc(1, 4'hD, 3'h2, 32'hFFFFFFFE, 1'b1);
        idx <= 1'b1;
        acc(1, 4'hD, 3'h2, 32'hA, 1'b1);
        wait_clk(5); chk(evok, 1);
        @(posedge clk) ebus <= 30'h28;
        @(posedge clk) ebus <= 30'h8;
        @(posedge clk) ebus <= 30'h0;
        k = 0;
        repeat (5) begin
            wait_clk(1);
            if (eovf[0] === 1'b1) k++;
        end
        chk(k, 1);
        acc(0, 4'hD, 3'h2, 32'h0, 1'b1); chk(rdata, 32'hB);
        acc(0, 4'hD, 3'h2, 32'h0, 1'b0); chk(rdata, 32'hB);
        idx <= 1'b0;
        acc(0, 4'hD, 3'h2, 32'h0, 1'b1); chk(rdata, 32'h0);
    endtask
    task tally_and_finish;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // whole run is under 500 cycles
    initial begin
        #20000;
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        {wr, rd, priv, idx, bit5, sec, usr, sun, dbg, ndbg, sdbg, sndbg} = '0;
        {crm, opc2, wdata, sel0, sel1, ebus, cen, ovf} = '0;
        crn = 4'h9;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_user;
        t_irq;
        t_unmapped;
        t_irqout;
        t_gate;
        t_count;
        tally_and_finish;
    end
endmodule

// [testbench/pmu_gate_monitor.sv]
// assertion checker for the event counter gating block
`timescale 1ns/100ps
module pmu_gate_monitor (
    input logic        SYS_CLK_I,
    input logic        RST_I,
    input logic        CP_WR_I,
    input logic        CP_RD_I,
    input logic [3:0]  CP_CRN_I,
    input logic [3:0]  CP_CRM_I,
    input logic [2:0]  CP_OPC2_I,
    input logic        CP_PRIV_I,
    input logic [31:0] CP_RDATA_O,
    input logic        CP_RVALID_O,
    input logic        CP_FAULT_O,
    input logic [2:0]  OVF_PENDING_I,
    input logic        MONITOR_CONTROL_BIT5_I,
    input logic        SECURE_STATE_I,
    input logic        USER_MODE_I,
    input logic        SECURE_USER_NONINVASIVE_BIT_I,
    input logic        INVASIVE_DEBUG_ALLOW_I,
    input logic        SECURE_INVASIVE_DEBUG_ALLOW_I,
    input logic        SECURE_NONINVASIVE_DEBUG_ALLOW_I,
    input logic        EVENT_COUNT_ALLOW_O,
    input logic        CYCLE_TALLY_ALLOW_O,
    input logic        MONITOR_IRQ_OUT_O
);
    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    wire ctl = (CP_CRN_I == 4'h9) && (CP_CRM_I == 4'hE);
    wire sec_no = SECURE_STATE_I && !(USER_MODE_I && SECURE_USER_NONINVASIVE_BIT_I);
    a_read_valid: assert property (CP_RD_I |=> CP_RVALID_O)
        else $error("read gave no valid pulse");
    a_user_irq_fault: assert property (CP_WR_I && ctl && !CP_PRIV_I
        && (CP_OPC2_I == 3'h1 || CP_OPC2_I == 3'h2)
        |=> CP_FAULT_O) else $error("user irq enable write not refused");
    a_user_reg_zero: assert property (CP_RD_I && ctl && CP_OPC2_I == 3'h0
        |=> CP_RDATA_O[31:1] == 31'h0) else $error("user access upper bits set");
    a_irq_read_resv: assert property (CP_RD_I && ctl && CP_PRIV_I
        && (CP_OPC2_I == 3'h1 || CP_OPC2_I == 3'h2)
        |=> CP_RDATA_O[30:2] == 29'h0) else $error("irq enable reserved bits set");
    a_irq_has_cause: assert property (MONITOR_IRQ_OUT_O |-> $past(OVF_PENDING_I) != 3'h0)
        else $error("irq without pending overflow");
    a_cycle_gate: assert property (CYCLE_TALLY_ALLOW_O && !EVENT_COUNT_ALLOW_O
        |-> !$past(MONITOR_CONTROL_BIT5_I)) else $error("cycle tally ran with bit 5 set");
    a_event_implies: assert property (EVENT_COUNT_ALLOW_O |-> CYCLE_TALLY_ALLOW_O)
        else $error("event allowed but cycle tally stopped");
    a_nonsec_allow: assert property ((!SECURE_STATE_I && INVASIVE_DEBUG_ALLOW_I)[*4]
        |=> EVENT_COUNT_ALLOW_O) else $error("non-secure counting refused");
    a_secure_forbid: assert property ((sec_no && !SECURE_INVASIVE_DEBUG_ALLOW_I
        && !SECURE_NONINVASIVE_DEBUG_ALLOW_I)[*4] |=> !EVENT_COUNT_ALLOW_O)
        else $error("secure counting allowed");
endmodule
bind perf_event_counter_gating_irq pmu_gate_monitor u_mon (.*);

// [verilog/event_tally.v]
// one 32-bit event counter with software load and overflow pulse
`timescale 1ns/100ps
module event_tally #(
    parameter WIDTH = 32
) (
    input  wire             SYS_CLK_I,
    input  wire             RST_I,
    input  wire             INC_I,
    input  wire             LOAD_I,
    input  wire [WIDTH-1:0] LOAD_DATA_I,
    output reg  [WIDTH-1:0] VALUE_O,
    output reg              OVF_O
);

    // a software load in the same cycle as an event wins; the event is dropped
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            VALUE_O <= {WIDTH{1'b0}};
            OVF_O   <= 1'b0;
        end else if (LOAD_I) begin
            VALUE_O <= LOAD_DATA_I;
            OVF_O   <= 1'b0;
        end else if (INC_I) begin
            VALUE_O <= VALUE_O + {{(WIDTH-1){1'b0}}, 1'b1};
            OVF_O   <= &VALUE_O;
        end else begin
            OVF_O   <= 1'b0;
        end
    end

endmodule

// [verilog/perf_event_counter_gating_irq.v]
// performance monitor event counters, counting permission and overflow irq enables
`timescale 1ns/100ps
`include "pmu_evt_consts.vh"
module perf_event_counter_gating_irq #(
    parameter CNT_WIDTH = 32,
    parameter BUS_WIDTH = 30
) (
    input  wire                 SYS_CLK_I,
    input  wire                 RST_I,
    // coprocessor register transfer
    input  wire                 CP_WR_I,
    input  wire                 CP_RD_I,
    input  wire [3:0]           CP_CRN_I,
    input  wire [3:0]           CP_CRM_I,
    input  wire [2:0]           CP_OPC2_I,
    input  wire [31:0]          CP_WDATA_I,
    input  wire                 CP_PRIV_I,
    output reg  [31:0]          CP_RDATA_O,
    output reg                  CP_RVALID_O,
    output reg                  CP_FAULT_O,
    // neighbouring units
    input  wire                 COUNTER_INDEX_I,
    input  wire [4:0]           EVENT_TYPE_SELECT0_I,
    input  wire [4:0]           EVENT_TYPE_SELECT1_I,
    input  wire [BUS_WIDTH-1:0] EVENT_BUS_I,
    input  wire [1:0]           COUNT_ENABLE_I,
    input  wire                 MONITOR_CONTROL_BIT5_I,
    input  wire [2:0]           OVF_PENDING_I,
    // processor state
    input  wire                 SECURE_STATE_I,
    input  wire                 USER_MODE_I,
    input  wire                 SECURE_USER_NONINVASIVE_BIT_I,
    // debug authentication pins
    input  wire                 INVASIVE_DEBUG_ALLOW_I,
    input  wire                 NONINVASIVE_DEBUG_ALLOW_I,
    input  wire                 SECURE_INVASIVE_DEBUG_ALLOW_I,
    input  wire                 SECURE_NONINVASIVE_DEBUG_ALLOW_I,
    // results
    output reg                  EVENT_COUNT_ALLOW_O,
    output reg                  CYCLE_TALLY_ALLOW_O,
    output reg  [1:0]           EVENT_OVF_O,
    output reg                  MONITOR_IRQ_OUT_O
);

    // ************************************************
    // functions
    // ************************************************
    function sel_event;
        input [BUS_WIDTH-1:0] bus;
        input [4:0]           idx;
        begin
            sel_event = (idx < BUS_WIDTH) ? bus[idx] : 1'b0;
        end
    endfunction

    // ************************************************
    // debug pin synchronisers
    // ************************************************
    reg  [3:0] dbg_meta_r;
    reg  [3:0] dbg_sync_r;

    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            dbg_meta_r <= 4'h0;
            dbg_sync_r <= 4'h0;
        end else begin
            dbg_meta_r <= {SECURE_NONINVASIVE_DEBUG_ALLOW_I, SECURE_INVASIVE_DEBUG_ALLOW_I,
                           NONINVASIVE_DEBUG_ALLOW_I, INVASIVE_DEBUG_ALLOW_I};
            dbg_sync_r <= dbg_meta_r;
        end
    end

    // ************************************************
    // counting permission
    // ************************************************
    wire debug_on    = dbg_sync_r[0] | dbg_sync_r[1];
    wire sec_debug   = dbg_sync_r[2] | dbg_sync_r[3];
    // debug allowed, and non-secure, secure debug, or secure user with the user bit
    wire event_allow = debug_on & (~SECURE_STATE_I | sec_debug
                       | (USER_MODE_I & SECURE_USER_NONINVASIVE_BIT_I));
    wire cycle_allow = event_allow | ~MONITOR_CONTROL_BIT5_I;

    // ************************************************
    // access decode
    // ************************************************
    reg        user_en_r;
    reg  [2:0] irq_en_r;    // {cycle, tally1, tally0}
    wire [CNT_WIDTH-1:0] tally0_value;
    wire [CNT_WIDTH-1:0] tally1_value;
    wire [1:0]           tally_ovf;

    wire c9_hit      = (CP_CRN_I == `PMU_CRN_C9);
    wire hit_value   = c9_hit & (CP_CRM_I == `PMU_CRM_COUNTER)
                       & (CP_OPC2_I == `PMU_OPC2_EVT_VALUE);
    wire hit_user    = c9_hit & (CP_CRM_I == `PMU_CRM_CONTROL)
                       & (CP_OPC2_I == `PMU_OPC2_USER_ACCESS);
    wire hit_set     = c9_hit & (CP_CRM_I == `PMU_CRM_CONTROL)
                       & (CP_OPC2_I == `PMU_OPC2_IRQ_SET);
    wire hit_clear   = c9_hit & (CP_CRM_I == `PMU_CRM_CONTROL)
                       & (CP_OPC2_I == `PMU_OPC2_IRQ_CLEAR);
    // user mode reaches the counters when enabled and may read the user enable; irq enables never open to user mode
    wire value_ok    = CP_PRIV_I | user_en_r;
    wire irq_ok      = CP_PRIV_I;
    wire value_wr    = CP_WR_I & hit_value & value_ok;
    wire user_wr     = CP_WR_I & hit_user & CP_PRIV_I;
    wire set_wr      = CP_WR_I & hit_set & irq_ok;
    wire clear_wr    = CP_WR_I & hit_clear & irq_ok;
    wire access      = CP_WR_I | CP_RD_I;
    wire denied      = access & (((hit_value & ~value_ok) | ((hit_set | hit_clear) & ~irq_ok))
                       | (CP_WR_I & hit_user & ~CP_PRIV_I));

    // ************************************************
    // the two event counters
    // ************************************************
    wire [2:0] irq_wmask = {CP_WDATA_I[`PMU_IRQ_CYCLE_BIT], CP_WDATA_I[`PMU_IRQ_TALLY1_BIT],
                            CP_WDATA_I[`PMU_IRQ_TALLY0_BIT]};
    wire inc0 = event_allow & COUNT_ENABLE_I[0]
                & sel_event(EVENT_BUS_I, EVENT_TYPE_SELECT0_I);
    wire inc1 = event_allow & COUNT_ENABLE_I[1]
                & sel_event(EVENT_BUS_I, EVENT_TYPE_SELECT1_I);

    // two 32-bit counters, one copy for both security states
    event_tally #(
        .WIDTH       (CNT_WIDTH)
    ) u_tally0 (
        .SYS_CLK_I   (SYS_CLK_I),
        .RST_I       (RST_I),
        .INC_I       (inc0),
        .LOAD_I      (value_wr & ~COUNTER_INDEX_I),
        .LOAD_DATA_I (CP_WDATA_I[CNT_WIDTH-1:0]),
        .VALUE_O     (tally0_value),
        .OVF_O       (tally_ovf[0])
    );

    event_tally #(
        .WIDTH       (CNT_WIDTH)
    ) u_tally1 (
        .SYS_CLK_I   (SYS_CLK_I),
        .RST_I       (RST_I),
        .INC_I       (inc1),
        .LOAD_I      (value_wr & COUNTER_INDEX_I),
        .LOAD_DATA_I (CP_WDATA_I[CNT_WIDTH-1:0]),
        .VALUE_O     (tally1_value),
        .OVF_O       (tally_ovf[1])
    );

    // ************************************************
    // control registers
    // ************************************************
    // single copies, the security state plays no part in them
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            user_en_r <= `PMU_USER_EN_RST;
            irq_en_r  <= `PMU_IRQ_EN_RST;
        end else begin
            if (user_wr) begin
                user_en_r <= CP_WDATA_I[`PMU_USER_EN_BIT];
            end
            if (set_wr) begin
                irq_en_r <= irq_en_r | irq_wmask;
            end else if (clear_wr) begin
                irq_en_r <= irq_en_r & ~irq_wmask;
            end
        end
    end

    // ************************************************
    // read data
    // ************************************************
    reg [31:0] rdata_nxt;

    always @* begin
        rdata_nxt = `PMU_RDATA_RST;
        if (hit_value & value_ok) begin
            rdata_nxt = COUNTER_INDEX_I ? tally1_value : tally0_value;
        end else if (hit_user) begin
            rdata_nxt[`PMU_USER_EN_BIT] = user_en_r;
        end else if ((hit_set | hit_clear) & irq_ok) begin
            rdata_nxt[`PMU_IRQ_CYCLE_BIT]  = irq_en_r[2];
            rdata_nxt[`PMU_IRQ_TALLY1_BIT] = irq_en_r[1];
            rdata_nxt[`PMU_IRQ_TALLY0_BIT] = irq_en_r[0];
        end
    end

    // ************************************************
    // registered outputs
    // ************************************************
    always @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            CP_RDATA_O          <= `PMU_RDATA_RST;
            CP_RVALID_O         <= 1'b0;
            CP_FAULT_O          <= 1'b0;
            EVENT_COUNT_ALLOW_O <= 1'b0;
            CYCLE_TALLY_ALLOW_O <= 1'b0;
            EVENT_OVF_O         <= 2'h0;
            MONITOR_IRQ_OUT_O   <= 1'b0;
        end else begin
            CP_RDATA_O          <= CP_RD_I ? rdata_nxt : `PMU_RDATA_RST;
            CP_RVALID_O         <= CP_RD_I;
            CP_FAULT_O          <= denied;
            EVENT_COUNT_ALLOW_O <= event_allow;
            CYCLE_TALLY_ALLOW_O <= cycle_allow;
            EVENT_OVF_O         <= tally_ovf;
            // level, follows pending flags held by the overflow status unit
            MONITOR_IRQ_OUT_O   <= |(OVF_PENDING_I & irq_en_r);
        end
    end

endmodule

// [verilog/pmu_evt_consts.vh]
// constants for the performance monitor event counter block
`ifndef PMU_EVT_CONSTS_VH
`define PMU_EVT_CONSTS_VH

// ************************************************
// coprocessor register selection (c9 space)
// ************************************************
`define PMU_CRN_C9            4'h9
`define PMU_CRM_COUNTER       4'hD
`define PMU_CRM_CONTROL       4'hE
`define PMU_OPC2_EVT_VALUE    3'h2
`define PMU_OPC2_USER_ACCESS  3'h0
`define PMU_OPC2_IRQ_SET      3'h1
`define PMU_OPC2_IRQ_CLEAR    3'h2

// ************************************************
// field positions
// ************************************************
`define PMU_USER_EN_BIT       0
`define PMU_IRQ_CYCLE_BIT     31
`define PMU_IRQ_TALLY1_BIT    1
`define PMU_IRQ_TALLY0_BIT    0

// ************************************************
// reset values
// ************************************************
`define PMU_USER_EN_RST       1'h0
`define PMU_IRQ_EN_RST        3'h0
`define PMU_TALLY_RST         32'h0000_0000
`define PMU_RDATA_RST         32'h0000_0000

`endif
